// ### rtl/lane_formatter.v
// Lane formatter: maps frame samples to link A and B lane octets and inserts test patterns.
// Assumes frame_samples_in is presented once per clock and a serializer sends bit 7 first.
`timescale 1ns/100ps
`include "lane_fmt_defs.vh"

module lane_formatter #(
  parameter FLUSH_CYCLES = `FLUSH_CYCLES_DEF
) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire [`MODE_W-1:0] link_mode_select_in,
  input wire [`TEST_W-1:0] test_pattern_select_in,
  input wire sh_fec_select_in,
  input wire powerdown_pin_in,
  input wire powerdown_cfg_in,
  input wire chan_a_pd_in,
  input wire chan_b_pd_in,
  input wire link_enable_in,
  input wire ila_done_in,
  input wire serdes_ready_in,
  input wire frame_valid_in,
  input wire [`FRAME_W-1:0] frame_samples_in,
  output reg [`LINK_W-1:0] link_a_lanes_out,
  output reg [`LINK_W-1:0] link_b_lanes_out,
  output reg [`LANES_PER_LINK-1:0] link_a_lane_en_out,
  output reg [`LANES_PER_LINK-1:0] link_b_lane_en_out,
  output reg coding_64b66b_out,
  output reg sh_fec_mode_out,
  output reg sh_crc12_mode_out,
  output reg link_bypass_out,
  output reg samples_invalid_out,
  output reg link_restart_out,
  output reg test_select_error_out
);

  // Lanes used per link for a mode; zero for reserved modes
  function [3:0] mode_lanes;
    input [`MODE_W-1:0] m;
    begin
      case (m)
        `MODE_S4C, `MODE_D4C: mode_lanes = 4'h2;
        `MODE_S8, `MODE_D8, `MODE_S8C, `MODE_D8C: mode_lanes = 4'h4;
        `MODE_S16, `MODE_D16, `MODE_S16C, `MODE_D16C: mode_lanes = 4'h8;
        default: mode_lanes = 4'h0;
      endcase
    end
  endfunction

  function mode_dual;
    input [`MODE_W-1:0] m;
    begin
      case (m)
        `MODE_D8, `MODE_D16, `MODE_D4C, `MODE_D8C, `MODE_D16C: mode_dual = 1'b1;
        default: mode_dual = 1'b0;
      endcase
    end
  endfunction

  function mode_66;
    input [`MODE_W-1:0] m;
    begin
      case (m)
        `MODE_S4C, `MODE_D4C, `MODE_S8C, `MODE_D8C, `MODE_S16C, `MODE_D16C: mode_66 = 1'b1; // RULE24
        default: mode_66 = 1'b0;
      endcase
    end
  endfunction

  // Eight PRBS steps; newest bit lands in bit 0, so bits 7..0 are sent oldest first
  function [`LFSR_W-1:0] prbs_step8;
    input [`LFSR_W-1:0] s;
    input [`TEST_W-1:0] t;
    integer i;
    reg [`LFSR_W-1:0] v;
    reg nb;
    begin
      v = s;
      nb = 1'b0;
      for (i = 0; i < `OCTET_W; i = i + 1) begin
        case (t)
          `TEST_PRBS_ORDER7: nb = v[5] ^ v[6]; // RULE16
          `TEST_PRBS9: nb = v[4] ^ v[8]; // RULE17
          `TEST_PRBS15: nb = v[13] ^ v[14]; // RULE17
          `TEST_PRBS23: nb = v[17] ^ v[22]; // RULE18
          default: nb = v[27] ^ v[30]; // RULE18
        endcase
        v = {v[`LFSR_W-2:0], nb};
      end
      prbs_step8 = v;
    end
  endfunction

  // Distinct non-zero start for each lane
  function [`LFSR_W-1:0] prbs_seed;
    input [4:0] lane;
    begin
      prbs_seed = {26'h0, lane} + 31'h1; // RULE19
    end
  endfunction

  function is_prbs;
    input [`TEST_W-1:0] t;
    begin
      is_prbs = (t >= `TEST_PRBS_ORDER7) && (t <= `TEST_PRBS_ORDER31);
    end
  endfunction

  wire [3:0] lanes_w = mode_lanes(link_mode_select_in);
  wire dual_w = mode_dual(link_mode_select_in);
  wire c66_w = mode_66(link_mode_select_in);
  wire pd_all_w = powerdown_pin_in | powerdown_cfg_in; // RULE10
  wire pd_a_w = pd_all_w | (dual_w & chan_a_pd_in); // RULE11
  wire pd_b_w = pd_all_w | (dual_w & chan_b_pd_in); // RULE11
  wire ramp_go_w = c66_w ? serdes_ready_in : ila_done_in; // RULE22

  reg [`LFSR_W-1:0] lfsr_r [0:2*`LANES_PER_LINK-1];
  reg [`OCTET_W-1:0] ramp_r;
  reg ramp_run_r;
  reg clk_phase_r;
  reg pd_prev_r;
  reg [`TEST_W-1:0] test_r;
  reg [15:0] flush_cnt_r;
  reg [`LINK_W-1:0] lane_a_nxt;
  reg [`LINK_W-1:0] lane_b_nxt;
  reg [`LANES_PER_LINK-1:0] en_lane_nxt;
  reg [`OCTET_W-1:0] pat_a;
  reg [`OCTET_W-1:0] pat_b;
  integer k;

  // Enabled lane mask: lowest lanes only
  always @* begin
    en_lane_nxt = {`LANES_PER_LINK{1'b0}};
    for (k = 0; k < `LANES_PER_LINK; k = k + 1) begin
      if (k < lanes_w) begin
        en_lane_nxt[k] = 1'b1; // RULE23 RULE13
      end
    end
  end

  // Lane octet assembly for data and test patterns
  always @* begin
    lane_a_nxt = {`LINK_W{1'b0}}; // RULE2
    lane_b_nxt = {`LINK_W{1'b0}}; // RULE2
    pat_a = `OCT_ZERO;
    pat_b = `OCT_ZERO;
    for (k = 0; k < `LANES_PER_LINK; k = k + 1) begin
      if (en_lane_nxt[k]) begin
        case (test_r)
          `TEST_NONE: begin
            if (frame_valid_in) begin
              if (dual_w) begin
                pat_a = frame_samples_in[k*`OCTET_W +: `OCTET_W]; // RULE6 RULE7 RULE8
                pat_b = frame_samples_in[(k+`CHB_SLOT)*`OCTET_W +: `OCTET_W]; // RULE6 RULE7 RULE8
              end else begin
                pat_a = frame_samples_in[(2*k)*`OCTET_W +: `OCTET_W]; // RULE4 RULE5 RULE8
                pat_b = frame_samples_in[(2*k+1)*`OCTET_W +: `OCTET_W]; // RULE4 RULE5 RULE8
              end
            end else begin
              pat_a = `OCT_ZERO;
              pat_b = `OCT_ZERO;
            end
          end
          `TEST_CLOCK: begin
            pat_a = clk_phase_r ? `OCT_ZERO : `OCT_ONES; // RULE20
            pat_b = clk_phase_r ? `OCT_ZERO : `OCT_ONES; // RULE20
          end
          `TEST_RAMP: begin
            pat_a = ramp_run_r ? ramp_r : `OCT_ZERO; // RULE21
            pat_b = ramp_run_r ? ramp_r : `OCT_ZERO; // RULE21
          end
          default: begin
            pat_a = lfsr_r[k][`OCTET_W-1:0]; // RULE15
            pat_b = lfsr_r[k+`LANES_PER_LINK][`OCTET_W-1:0]; // RULE15
          end
        endcase
        if (!pd_a_w) begin
          lane_a_nxt[k*`OCTET_W +: `OCTET_W] = pat_a; // RULE1 RULE3
        end
        if (!pd_b_w) begin
          lane_b_nxt[k*`OCTET_W +: `OCTET_W] = pat_b; // RULE1 RULE3
        end
      end
    end
  end

  // Test select is latched only while the link is off
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      test_r <= `TEST_NONE;
      test_select_error_out <= 1'b0;
    end else if (!link_enable_in) begin
      test_r <= test_pattern_select_in; // RULE14
      test_select_error_out <= 1'b0;
    end else if (test_pattern_select_in != test_r) begin
      test_select_error_out <= 1'b1; // RULE14
    end
  end

  // PRBS generators, one per lane
  always @(posedge clk_sys_in) begin
    for (k = 0; k < 2*`LANES_PER_LINK; k = k + 1) begin
      if (reset_in || !is_prbs(test_r)) begin
        lfsr_r[k] <= prbs_seed(k[4:0]); // RULE19
      end else begin
        lfsr_r[k] <= prbs_step8(lfsr_r[k], test_r); // RULE16 RULE17 RULE18
      end
    end
  end

  // Clock pattern phase and ramp counter
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      clk_phase_r <= 1'b0;
      ramp_r <= `OCT_ZERO;
      ramp_run_r <= 1'b0;
    end else begin
      if (test_r == `TEST_CLOCK) begin
        clk_phase_r <= ~clk_phase_r; // RULE20
      end else begin
        clk_phase_r <= 1'b0;
      end
      if (test_r != `TEST_RAMP || !link_enable_in) begin
        ramp_run_r <= 1'b0;
        ramp_r <= `OCT_ZERO;
      end else if (ramp_run_r) begin
        ramp_r <= ramp_r + 8'h01; // RULE21
      end else if (ramp_go_w) begin
        ramp_run_r <= 1'b1; // RULE22
      end
    end
  end

  // Power-down exit: link restart pulse and flush window
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      pd_prev_r <= 1'b0;
      flush_cnt_r <= 16'h0000;
      samples_invalid_out <= 1'b0;
      link_restart_out <= 1'b0;
    end else begin
      pd_prev_r <= pd_all_w;
      link_restart_out <= pd_prev_r & ~pd_all_w; // RULE12
      if (pd_all_w) begin
        samples_invalid_out <= 1'b1; // RULE12
        flush_cnt_r <= FLUSH_CYCLES[15:0];
      end else if (flush_cnt_r != 16'h0000) begin
        flush_cnt_r <= flush_cnt_r - 16'h0001; // RULE12
        samples_invalid_out <= 1'b1;
      end else begin
        samples_invalid_out <= 1'b0;
      end
    end
  end

  // Registered lane outputs and mode indicators
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      link_a_lanes_out <= {`LINK_W{1'b0}};
      link_b_lanes_out <= {`LINK_W{1'b0}};
      link_a_lane_en_out <= {`LANES_PER_LINK{1'b0}};
      link_b_lane_en_out <= {`LANES_PER_LINK{1'b0}};
      coding_64b66b_out <= 1'b0;
      sh_fec_mode_out <= 1'b0;
      sh_crc12_mode_out <= 1'b0;
      link_bypass_out <= 1'b0;
    end else begin
      link_a_lanes_out <= lane_a_nxt; // RULE25
      link_b_lanes_out <= lane_b_nxt; // RULE25
      link_a_lane_en_out <= pd_a_w ? {`LANES_PER_LINK{1'b0}} : en_lane_nxt; // RULE10 RULE23
      link_b_lane_en_out <= pd_b_w ? {`LANES_PER_LINK{1'b0}} : en_lane_nxt; // RULE10 RULE23
      coding_64b66b_out <= c66_w; // RULE24
      sh_fec_mode_out <= c66_w & sh_fec_select_in; // RULE9
      sh_crc12_mode_out <= c66_w & ~sh_fec_select_in; // RULE9
      link_bypass_out <= is_prbs(test_r) | (test_r == `TEST_CLOCK); // RULE15 RULE20
    end
  end

endmodule // lane_formatter

// ### rtl/lane_fmt_defs.vh
// Constants for the serial lane formatter: link modes, test selects, widths.
// Assumes one 10 MHz frame clock and a serializer that sends octet bit 7 first.
// How it works
// RULE1 - each 8-bit offset-binary sample fills exactly one lane octet
// RULE2 - tail and unused bit positions are always driven to zero
// RULE3 - octets go out MSB first, LSB last
// RULE4 - modes 5 and 44: A lane k gets S[2k], B lane k gets S[2k+1], k 0..3
// RULE5 - modes 6 and 50: same interleave over lanes 0..7
// RULE6 - modes 7 and 45: A lane k gets A[k], B lane k gets B[k], k 0..3
// RULE7 - modes 8 and 51: same channel split over lanes 0..7
// RULE8 - mode 34 single interleave on two lanes; mode 35 channel split on two lanes
// RULE9 - 64b/66b header stream is CRC-12 or FEC by select; no CRC-3
// RULE10 - power-down pin or config bit powers down all and disables drivers
// RULE11 - in dual mode one channel can be powered down alone
// RULE12 - after power-down the link restarts and samples are flagged invalid until flushed
// RULE13 - test select picks mode; lane count follows link mode always
// RULE14 - test select changes only while the link is disabled
// RULE15 - PRBS bits bypass transport and link layers, unscrambled and unencoded
// RULE16 - PRBS_ORDER7: bit is XOR of bits 6 and 7 back, length 127
// RULE17 - PRBS9 taps 5 and 9, PRBS15 taps 14 and 15
// RULE18 - PRBS23 taps 18 and 23, PRBS_ORDER31 taps 28 and 31
// RULE19 - each lane starts its PRBS at a different phase
// RULE20 - clock pattern: eight ones then eight zeros, bypassing link layers
// RULE21 - ramp: input ignored, identical wrapping 0x00..0xff octet on every lane
// RULE22 - ramp starts after ILA for 8b/10b, after serializer init for 64b/66b
// RULE23 - only lowest lanes of each link used; higher lanes powered down
// RULE24 - modes 5..8 use 8b/10b; 34, 35, 44, 45, 50, 51 use 64b/66b
// RULE25 - mapping applied once per frame cycle, samples in time order
`ifndef LANE_FMT_DEFS_VH
`define LANE_FMT_DEFS_VH

`define MODE_W 7
`define MODE_S8 7'h05
`define MODE_S16 7'h06
`define MODE_D8 7'h07
`define MODE_D16 7'h08
`define MODE_S4C 7'h22
`define MODE_D4C 7'h23
`define MODE_S8C 7'h2c
`define MODE_D8C 7'h2d
`define MODE_S16C 7'h32
`define MODE_D16C 7'h33

`define TEST_W 3
`define TEST_NONE 3'h0
`define TEST_PRBS_ORDER7 3'h1
`define TEST_PRBS9 3'h2
`define TEST_PRBS15 3'h3
`define TEST_PRBS23 3'h4
`define TEST_PRBS_ORDER31 3'h5
`define TEST_CLOCK 3'h6
`define TEST_RAMP 3'h7

`define LANES_PER_LINK 8
`define OCTET_W 8
`define LINK_W 64
`define FRAME_W 128
`define CHB_SLOT 8
`define LFSR_W 31
`define OCT_ONES 8'hff
`define OCT_ZERO 8'h00
`define FLUSH_CYCLES_DEF 64

`endif

// ### dv/lane_formatter_chk.sv
// Port checker for the lane formatter.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module lane_formatter_chk #(parameter FLUSH_CYCLES = 4) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire [6:0] link_mode_select_in,
  input wire [2:0] test_pattern_select_in,
  input wire sh_fec_select_in,
  input wire powerdown_pin_in,
  input wire powerdown_cfg_in,
  input wire chan_a_pd_in,
  input wire chan_b_pd_in,
  input wire link_enable_in,
  input wire frame_valid_in,
  input wire [127:0] frame_samples_in,
  input wire [63:0] link_a_lanes_out,
  input wire [63:0] link_b_lanes_out,
  input wire [7:0] link_a_lane_en_out,
  input wire [7:0] link_b_lane_en_out,
  input wire coding_64b66b_out,
  input wire sh_fec_mode_out,
  input wire sh_crc12_mode_out,
  input wire samples_invalid_out,
  input wire link_restart_out
);
  wire [6:0] m = link_mode_select_in;
  wire pd = powerdown_pin_in | powerdown_cfg_in;
  wire [7:0] en = (m == 7'h22 || m == 7'h23) ? 8'h03 : (m == 7'h06 || m == 7'h08 || m[6:1] == 6'h19) ? 8'hff
    : (m == 7'h05 || m == 7'h07 || m[6:1] == 6'h16) ? 8'h0f : 8'h00;
  wire c64 = m > 7'h08 && en != 8'h00;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_pd_off: assert property (pd |=> {link_a_lanes_out, link_b_lanes_out, link_a_lane_en_out, link_b_lane_en_out} == 0)
    else $error("drivers active in power-down");
  a_pd_invalid: assert property (pd |=> samples_invalid_out)
    else $error("samples not flagged invalid");
  a_restart_pulse: assert property ($fell(pd) |-> ##1 link_restart_out ##1 !link_restart_out)
    else $error("no single restart pulse");
  a_lane_count: assert property (!pd && !chan_a_pd_in && !chan_b_pd_in |=>
    link_a_lane_en_out == $past(en) && link_b_lane_en_out == $past(en)) else $error("lane enables wrong");
  a_line_code: assert property (!pd |=> coding_64b66b_out == $past(c64))
    else $error("line coding wrong");
  a_header_sel: assert property (!pd |=> {sh_fec_mode_out, sh_crc12_mode_out} ==
    ($past(c64) ? {$past(sh_fec_select_in), !$past(sh_fec_select_in)} : 2'b00)) else $error("header stream wrong");
  a_chan_down: assert property (!pd && m == 7'h07 && chan_b_pd_in && !chan_a_pd_in |=>
    link_b_lane_en_out == 8'h00 && link_a_lane_en_out == 8'h0f) else $error("channel power-down wrong");
  a_data_map: assert property (!pd && !samples_invalid_out && m == 7'h05 && frame_valid_in && !link_enable_in
    && !$past(link_enable_in) && test_pattern_select_in == 0 && $past(test_pattern_select_in) == 0
    |=> link_a_lanes_out[7:0] == $past(frame_samples_in[7:0]) && link_b_lanes_out[7:0] == $past(frame_samples_in[15:8]))
    else $error("sample mapping wrong");
endmodule // lane_formatter_chk
bind lane_formatter lane_formatter_chk #(.FLUSH_CYCLES(FLUSH_CYCLES)) chk_i (.*);

// ### dv/prbs_rx_model.sv
// PRBS receiver model: self-syncs to one lane and counts recurrence misses.
// Assumes octet bit 7 goes first and taps are steady while running.
`timescale 1ns/100ps
module prbs_rx_model (
  input wire clk_sys_in,
  input wire clr_in,
  input wire run_in,
  input wire [7:0] octet_in,
  input wire [5:0] tap_a_in,
  input wire [5:0] tap_b_in,
  output int err_out,
  output int bits_out
);
  logic [63:0] hist;
  always @(posedge clk_sys_in) begin
    if (clr_in) begin
      err_out = 0;
      bits_out = 0;
    end else if (run_in) begin
      for (int i = 7; i >= 0; i--) begin
        if (bits_out >= tap_b_in && octet_in[i] !== (hist[tap_a_in-1] ^ hist[tap_b_in-1]))
          err_out++;
        hist = {hist[62:0], octet_in[i]};
        bits_out++;
      end
    end
  end
endmodule // prbs_rx_model

// ### dv/tb_top.sv
// Self-checking bench for the lane formatter with a PRBS receiver model.
// Assumes design, checker and model are compiled first; inputs move on falling edges.
`timescale 1ns/100ps
module tb_top;
  logic clk_sys_in = 0, reset_in = 1, sh_fec_select_in = 0, powerdown_cfg_in = 0, chan_a_pd_in = 0, chan_b_pd_in = 0;
  logic ila_done_in = 0, serdes_ready_in = 0, frame_valid_in = 0, pdp = 0, len = 0, clr = 1, d, x;
  logic [6:0] md = 0;
  logic [2:0] tst = 0;
  logic [127:0] frame_samples_in = 0;
  logic [63:0] la, lb, xa, xb;
  logic [7:0] ea, link_b_lane_en_out, xe, p;
  logic [5:0] ta = 6, tb = 7;
  logic coding_64b66b_out, sh_fec_mode_out, sh_crc12_mode_out, byp, samples_invalid_out, link_restart_out;
  logic test_select_error_out;
  int n_fail = 0, total_checks = 0, perr, pbits, j, k;
  logic [16:0] rows [10] = '{{7'h05, 2'b00, 8'h0f}, {7'h06, 2'b00, 8'hff}, {7'h07, 2'b10, 8'h0f}, {7'h08, 2'b10, 8'hff},
    {7'h22, 2'b01, 8'h03}, {7'h23, 2'b11, 8'h03}, {7'h2c, 2'b01, 8'h0f}, {7'h2d, 2'b11, 8'h0f}, {7'h32, 2'b01, 8'hff},
    {7'h33, 2'b11, 8'hff}};
  logic [5:0] tpa [5] = '{6'd6, 6'd5, 6'd14, 6'd18, 6'd28};
  logic [5:0] tpb [5] = '{6'd7, 6'd9, 6'd15, 6'd23, 6'd31};
  lane_formatter #(.FLUSH_CYCLES(4)) dut (.*, .link_mode_select_in(md), .test_pattern_select_in(tst),
    .powerdown_pin_in(pdp), .link_enable_in(len), .link_a_lanes_out(la), .link_b_lanes_out(lb),
    .link_a_lane_en_out(ea), .link_bypass_out(byp));
  prbs_rx_model rx (.clk_sys_in(clk_sys_in), .clr_in(clr), .run_in(byp), .octet_in(la[7:0]), .tap_a_in(ta),
    .tap_b_in(tb), .err_out(perr), .bits_out(pbits));
  always #50 clk_sys_in = ~clk_sys_in;
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    for (k = 0; k < 16; k++)
      frame_samples_in[8*k+:8] = {k[3:0], ~k[3:0]};
    step(21);
    reset_in = 0;
    chk("reset outputs", 0, {la[31:0], ea, link_b_lane_en_out, samples_invalid_out, link_restart_out, byp});
    frame_valid_in = 1;
    for (j = 0; j < 10; j++) begin
      {md, d, x, xe} = rows[j];
      step(1);
      xa = 0;
      xb = 0;
      for (k = 0; k < 8; k++)
        if (xe[k]) begin
          xa[8*k+:8] = frame_samples_in[8*(d ? k : 2*k)+:8];
          xb[8*k+:8] = frame_samples_in[8*(d ? k+8 : 2*k+1)+:8];
        end
      chk("link a lanes", xa, la);
      chk("link b lanes", xb, lb);
      chk("lane enables", {xe, xe}, {ea, link_b_lane_en_out});
      chk("header mode", {x, x, 1'b0}, {coding_64b66b_out, sh_crc12_mode_out, sh_fec_mode_out});
    end
    sh_fec_select_in = 1;
    step(1);
    chk("fec header", 2'b10, {sh_fec_mode_out, sh_crc12_mode_out});
    md = 7'h07;
    chan_b_pd_in = 1;
    step(1);
    chk("channel down", 16'h0f00, {ea, link_b_lane_en_out});
    md = 7'h05;
    chan_b_pd_in = 0;
    powerdown_cfg_in = 1;
    step(1);
    powerdown_cfg_in = 0;
    pdp = 1;
    step(1);
    chk("power-down", 1, {la[31:0], ea, link_b_lane_en_out, samples_invalid_out});
    pdp = 0;
    step(1);
    chk("restart pulse", 2'b11, {link_restart_out, samples_invalid_out});
    k = 0;
    while (samples_invalid_out && k < 40) begin
      step(1);
      k++;
    end
    chk("flush wait", 1, k == 4);
    if (k == 40)
      close_out();
    tst = 6;
    step(3);
    p = la[7:0];
    step(1);
    chk("clock pattern", {~p, 2'b11}, {la[7:0], byp, p == 8'hff || p == 8'h00});
    for (j = 0; j < 5; j++) begin
      tst = 3'(j + 1);
      ta = tpa[j];
      tb = tpb[j];
      clr = 1;
      p = 0;
      step(3);
      clr = 0;
      repeat (10) begin
        step(1);
        p = p | (la[7:0] ^ la[15:8]);
      end
      chk("prbs errors", 0, perr);
      chk("prbs bits", 80, pbits);
      chk("lane phases", 1, p != 0);
    end
    len = 1;
    tst = 0;
    step(2);
    chk("select refused", 2'b11, {test_select_error_out, byp});
    tst = 7;
    for (j = 0; j < 2; j++) begin
      len = 0;
      ila_done_in = 0;
      serdes_ready_in = 0;
      md = j ? 7'h2c : 7'h05;
      step(2);
      len = 1;
      ila_done_in = !j;
      serdes_ready_in = j[0];
      step(2);
      for (k = 0; k < 260; k++) begin
        chk("ramp octets", {8{k[7:0]}}, {la[31:0], lb[31:0]});
        step(1);
      end
    end
    close_out();
  end
endmodule // tb_top
